//--- src/smt_pkg.sv
// constants, register map and types of the sdram pattern memory test
package smt_pkg;
    // ========================================================
    // data path and memory size
    localparam int unsigned DATA_W = 32;
    localparam int unsigned MEM_WORDS_DEF = 67108864;
    // ========================================================
    // clocking
    localparam int unsigned OSC_FREQ_MHZ = 100;
    localparam int unsigned FIFO_CLOCK_DIVISOR = 2;
    localparam int unsigned FAST_THRESHOLD_MHZ = 60;
    localparam int unsigned BLINK_INTERVAL_MS = 1000;
    localparam int unsigned MCLK_PERIOD_NS = 10;
    // ========================================================
    // control word fields
    localparam int unsigned CW_SEL_LSB = 0;
    localparam int unsigned CW_SEL_W = 4;
    localparam int unsigned CW_WR_BIT = 4;
    localparam int unsigned CW_RD_BIT = 5;
    localparam int unsigned CW_UNUSED_LSB = 6;
    // ========================================================
    // pattern values
    localparam logic [31:0] PAT_ZEROS = 32'h00000000;
    localparam logic [31:0] PAT_ONES = 32'hFFFFFFFF;
    localparam logic [31:0] PAT_ALT01 = 32'h55555555;
    localparam logic [31:0] PAT_ALT10 = 32'hAAAAAAAA;
    localparam logic [31:0] PAT_COUNT_START = 32'h00000000;
    localparam logic [31:0] PAT_COUNT_STEP = 32'h00000001;
    localparam logic [31:0] PAT_WALK_START = 32'h00000001;
    localparam logic [31:0] PAT_WALK_TOP = 32'h80000000;
    // pattern select codes
    typedef enum logic [3:0] {
        SMT_SEL_ZEROS = 4'h0,
        SMT_SEL_ONES = 4'h1,
        SMT_SEL_ALT01 = 4'h2,
        SMT_SEL_ALT10 = 4'h3,
        SMT_SEL_COUNT = 4'h4,
        SMT_SEL_WALK = 4'h8
    } smt_sel_t;
    // ========================================================
    // register map (byte addresses)
    localparam int unsigned REG_AW = 4;
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_IRQ_STAT = 4'h4;
    localparam logic [3:0] REG_IRQ_MASK = 4'h8;
    localparam logic [3:0] REG_READ_WORDS = 4'hC;
    // interrupt bits
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_DONE = 0;
    localparam int unsigned IRQ_MISMATCH = 1;
    localparam int unsigned IRQ_BAD_CMD = 2;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;
    // status bits
    localparam int unsigned ST_BUSY_BIT = 0;
    localparam int unsigned ST_ERR_BIT = 1;
    localparam int unsigned ST_READING_BIT = 2;
    localparam int unsigned ST_SEL_LSB = 4;
    // ========================================================
    // control states
    typedef enum logic [2:0] {
        SMT_IDLE = 3'b000,
        SMT_WRITE = 3'b001,
        SMT_RD_REQ = 3'b010,
        SMT_RD_WAIT = 3'b011,
        SMT_OUT = 3'b100
    } smt_state_t;
endpackage : smt_pkg

//--- src/smt_pattern_gen.sv
// test pattern generator of the sdram pattern memory test
`timescale 1ns/100ps
module smt_pattern_gen (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] sel_i,
    input wire logic restart_i,
    input wire logic advance_i,
    output logic [smt_pkg::DATA_W-1:0] value_o
);
    import smt_pkg::*;

    // ========================================================
    // first value of each pattern
    function automatic logic [31:0] pat_init(input logic [3:0] sel);
        unique case (sel)
            SMT_SEL_ONES: pat_init = PAT_ONES;
            SMT_SEL_ALT01: pat_init = PAT_ALT01;
            SMT_SEL_ALT10: pat_init = PAT_ALT10;
            SMT_SEL_COUNT: pat_init = PAT_COUNT_START;
            SMT_SEL_WALK: pat_init = PAT_WALK_START;
            default: pat_init = PAT_ZEROS; // unknown codes give zeros
        endcase
    endfunction : pat_init

    // value that follows the current one
    function automatic logic [31:0] pat_next(input logic [3:0] sel, input logic [31:0] v);
        unique case (sel)
            SMT_SEL_COUNT: pat_next = v + PAT_COUNT_STEP;
            SMT_SEL_WALK: pat_next = {v[30:0], v[31]}; // wraps to bit zero
            default: pat_next = v;
        endcase
    endfunction : pat_next

    logic [31:0] value_q;
    logic [31:0] value_d;

    // restart beats advance
    assign value_d = restart_i ? pat_init(sel_i) : (advance_i ? pat_next(sel_i, value_q) : value_q);
    assign value_o = value_q;

    // ========================================================
    // pattern register
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            value_q <= PAT_ZEROS;
        end else begin
            value_q <= value_d;
        end
    end

    // ========================================================
    // checks
    sequence walk_at_top_s;
        advance_i && !restart_i && sel_i == SMT_SEL_WALK && value_q == PAT_WALK_TOP;
    endsequence
    walk_wrap_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        walk_at_top_s |=> value_q == PAT_WALK_START)
        else $error("walking one did not wrap to bit zero");
    count_step_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        advance_i && !restart_i && sel_i == SMT_SEL_COUNT |=> value_q == $past(value_q) + 32'h1)
        else $error("count pattern did not add one");
    walk_shift_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        restart_i && sel_i == SMT_SEL_WALK ##1 advance_i && !restart_i && sel_i == SMT_SEL_WALK
        |=> value_q == 32'h00000002)
        else $error("walking one did not shift left");
    const_ones_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        restart_i && sel_i == SMT_SEL_ONES |=> value_q == PAT_ONES)
        else $error("ones pattern wrong");
endmodule : smt_pattern_gen

//--- src/smt_mem_test.sv
// control state machine of the sdram pattern memory test
//
// Functional notes
// - zeros, ones and two alternating-bit constants
// - count starts at zero, adds one
// - walking one starts at bit zero, shifts
// - after top bit, back to bit zero
// - one output word per location read
// - indicator toggles about every second
// - fifo clock is oscillator or half
// - build option flags fifo clock above threshold
// - halved, global, slow flag: half rate
// - not halved, global, fast flag: full rate
// - control word: select, write, read, zeros
// - select codes map to six patterns
// - write all first, then read all
// - indicators show select, mismatch lights all
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/100ps
module smt_mem_test #(
    parameter bit HALVE_FIFO_CLOCK = 1'b0,
    parameter bit GLOBAL_FIFO_CLOCK_DOMAIN = 1'b1,
    parameter bit FIFO_CLOCK_FAST_FLAG = 1'b1,
    parameter int unsigned MEM_WORDS = smt_pkg::MEM_WORDS_DEF,
    parameter int unsigned ADDR_W = 26,
    parameter int unsigned BLINK_TICKS = (HALVE_FIFO_CLOCK ? smt_pkg::OSC_FREQ_MHZ
        / smt_pkg::FIFO_CLOCK_DIVISOR : smt_pkg::OSC_FREQ_MHZ) * smt_pkg::BLINK_INTERVAL_MS
        * 1000
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // input fifo (control words)
    input wire logic cmd_valid_i,
    input wire logic [smt_pkg::DATA_W-1:0] cmd_data_i,
    output logic cmd_ready_o,
    // output fifo (read data)
    output logic out_valid_o,
    output logic [smt_pkg::DATA_W-1:0] out_data_o,
    input wire logic out_ready_i,
    // memory port
    output logic mem_wr_o,
    output logic mem_rd_o,
    output logic [ADDR_W-1:0] mem_addr_o,
    output logic [smt_pkg::DATA_W-1:0] mem_wdata_o,
    input wire logic mem_ready_i,
    input wire logic mem_rvalid_i,
    input wire logic [smt_pkg::DATA_W-1:0] mem_rdata_i,
    // register port
    input wire logic [smt_pkg::REG_AW-1:0] reg_addr_i,
    input wire logic [smt_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [smt_pkg::DATA_W-1:0] reg_rdata_o,
    output logic irq_o,
    // clocking and indicators
    output logic fifo_tick_o,
    output logic fifo_clock_fast_flag_o,
    output logic clock_alive_indicator_o,
    output logic [3:0] pattern_leds_o
);
    import smt_pkg::*;

    // ========================================================
    // elaboration checks
    localparam int unsigned FIFO_MHZ = HALVE_FIFO_CLOCK ? OSC_FREQ_MHZ / FIFO_CLOCK_DIVISOR
        : OSC_FREQ_MHZ;
    localparam int unsigned BLINK_W = $clog2(BLINK_TICKS + 1);
    localparam logic [ADDR_W-1:0] LAST_ADDR = ADDR_W'(MEM_WORDS - 1);
    if (!GLOBAL_FIFO_CLOCK_DOMAIN) begin : g_domain_chk
        $error("only the global fifo clock domain is supported");
    end
    if ((FIFO_MHZ > FAST_THRESHOLD_MHZ) != FIFO_CLOCK_FAST_FLAG) begin : g_fast_chk
        $error("fast flag does not match the fifo clock rate");
    end
    if (MEM_WORDS < 2 || MEM_WORDS > (2 ** ADDR_W)) begin : g_size_chk
        $error("memory size does not fit the address width");
    end
    if (BLINK_TICKS < 2) begin : g_blink_chk
        $error("blink interval too short");
    end

    // ========================================================
    // fifo clock: full rate, or every second oscillator edge
    logic half_q;
    logic fifo_tick;
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            half_q <= 1'b0;
        end else begin
            half_q <= ~half_q;
        end
    end
    assign fifo_tick = HALVE_FIFO_CLOCK ? half_q : 1'b1;
    assign fifo_tick_o = fifo_tick;
    assign fifo_clock_fast_flag_o = FIFO_CLOCK_FAST_FLAG;

    // ========================================================
    // clock alive blinker counted in fifo clock ticks
    logic [BLINK_W-1:0] blink_cnt_q;
    logic blink_q;
    logic blink_wrap;
    assign blink_wrap = fifo_tick && blink_cnt_q == BLINK_W'(BLINK_TICKS - 1);
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            blink_cnt_q <= '0;
            blink_q <= 1'b0;
        end else if (blink_wrap) begin
            blink_cnt_q <= '0;
            blink_q <= ~blink_q;
        end else if (fifo_tick) begin
            blink_cnt_q <= blink_cnt_q + BLINK_W'(1);
        end
    end
    assign clock_alive_indicator_o = blink_q;

    // ========================================================
    // control word decode
    logic [3:0] cw_sel;
    logic cw_wr;
    logic cw_rd;
    logic cw_bad;
    assign cw_sel = cmd_data_i[CW_SEL_LSB +: CW_SEL_W];
    assign cw_wr = cmd_data_i[CW_WR_BIT];
    assign cw_rd = cmd_data_i[CW_RD_BIT];
    assign cw_bad = (|cmd_data_i[DATA_W-1:CW_UNUSED_LSB]) || !(cw_sel inside {SMT_SEL_ZEROS,
        SMT_SEL_ONES, SMT_SEL_ALT01, SMT_SEL_ALT10, SMT_SEL_COUNT, SMT_SEL_WALK});

    // ========================================================
    // control state machine
    smt_state_t state_q;
    smt_state_t state_d;
    logic [3:0] sel_q;
    logic rd_en_q;
    logic [ADDR_W-1:0] addr_q;
    logic err_q;
    logic [DATA_W-1:0] out_data_q;
    logic [DATA_W-1:0] words_q;
    logic [DATA_W-1:0] expect_val;
    logic cmd_take;
    logic wr_take;
    logic rd_take;
    logic rd_back;
    logic out_take;
    logic at_last;
    logic gen_restart;
    logic gen_advance;
    logic mismatch;
    logic iter_done;

    assign cmd_ready_o = state_q == SMT_IDLE && fifo_tick;
    assign cmd_take = cmd_valid_i && cmd_ready_o;
    assign wr_take = state_q == SMT_WRITE && mem_ready_i;
    assign rd_take = state_q == SMT_RD_REQ && mem_ready_i;
    assign rd_back = state_q == SMT_RD_WAIT && mem_rvalid_i;
    assign out_take = state_q == SMT_OUT && out_ready_i && fifo_tick;
    assign at_last = addr_q == LAST_ADDR;
    assign mismatch = rd_back && mem_rdata_i != expect_val;
    // restart on a new word and again when reading begins
    assign gen_restart = cmd_take || (wr_take && at_last);
    assign gen_advance = wr_take || rd_back;
    assign iter_done = (cmd_take && !cw_wr && !cw_rd) || (wr_take && at_last && !rd_en_q)
        || (out_take && at_last);
    assign mem_wr_o = state_q == SMT_WRITE;
    assign mem_rd_o = state_q == SMT_RD_REQ;
    assign mem_addr_o = addr_q;
    assign mem_wdata_o = expect_val;
    assign out_valid_o = state_q == SMT_OUT;
    assign out_data_o = out_data_q;
    assign pattern_leds_o = err_q ? 4'hF : sel_q;

    // next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            SMT_IDLE: begin
                if (cmd_take && cw_wr) begin
                    state_d = SMT_WRITE;
                end else if (cmd_take && cw_rd) begin
                    state_d = SMT_RD_REQ;
                end
            end
            SMT_WRITE: begin
                if (wr_take && at_last) begin
                    state_d = rd_en_q ? SMT_RD_REQ : SMT_IDLE;
                end
            end
            SMT_RD_REQ: begin
                if (rd_take) begin
                    state_d = SMT_RD_WAIT;
                end
            end
            SMT_RD_WAIT: begin
                if (rd_back) begin
                    state_d = SMT_OUT;
                end
            end
            SMT_OUT: begin
                if (out_take) begin
                    state_d = at_last ? SMT_IDLE : SMT_RD_REQ;
                end
            end
            default: state_d = SMT_IDLE;
        endcase
    end

    // state, command latch and address
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_q <= SMT_IDLE;
            sel_q <= 4'h0;
            rd_en_q <= 1'b0;
            addr_q <= '0;
        end else begin
            state_q <= state_d;
            if (cmd_take) begin
                sel_q <= cw_sel;
                rd_en_q <= cw_rd;
            end
            if (cmd_take || (wr_take && at_last) || (out_take && at_last)) begin
                addr_q <= '0;
            end else if (wr_take || out_take) begin
                addr_q <= addr_q + ADDR_W'(1);
            end
        end
    end

    // read data capture, error latch, word count
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            out_data_q <= '0;
            err_q <= 1'b0;
            words_q <= '0;
        end else begin
            if (rd_back) begin
                out_data_q <= mem_rdata_i;
            end
            if (mismatch) begin
                err_q <= 1'b1; // held until reset
            end
            if (cmd_take) begin
                words_q <= '0;
            end else if (out_take) begin
                words_q <= words_q + 32'h1;
            end
        end
    end

    // expected data, also the write data
    smt_pattern_gen u_gen (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .sel_i(cmd_take ? cw_sel : sel_q),
        .restart_i(gen_restart),
        .advance_i(gen_advance),
        .value_o(expect_val)
    );

    // ========================================================
    // interrupts: sticky status, write one to clear, set wins
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    assign irq_set[IRQ_DONE] = iter_done;
    assign irq_set[IRQ_MISMATCH] = mismatch;
    assign irq_set[IRQ_BAD_CMD] = cmd_take && cw_bad;
    assign irq_clr = (reg_wr_i && reg_addr_i == REG_IRQ_STAT) ? reg_wdata_i[IRQ_W-1:0] : '0;
    assign irq_o = |(irq_stat_q & irq_mask_q);
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            irq_stat_q <= '0;
            irq_mask_q <= IRQ_MASK_RST;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
            if (reg_wr_i && reg_addr_i == REG_IRQ_MASK) begin
                irq_mask_q <= reg_wdata_i[IRQ_W-1:0];
            end
        end
    end

    // ========================================================
    // register read port, data one cycle after the strobe
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] rd_mux;
    logic [DATA_W-1:0] reg_rdata_q;
    assign status_word = DATA_W'({sel_q, 1'b0, state_q inside {SMT_RD_REQ, SMT_RD_WAIT,
        SMT_OUT}, err_q, state_q != SMT_IDLE});
    assign rd_mux = (reg_addr_i == REG_STATUS) ? status_word
        : (reg_addr_i == REG_IRQ_STAT) ? DATA_W'(irq_stat_q)
        : (reg_addr_i == REG_IRQ_MASK) ? DATA_W'(irq_mask_q)
        : (reg_addr_i == REG_READ_WORDS) ? words_q : '0;
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            reg_rdata_q <= '0;
        end else begin
            reg_rdata_q <= reg_rd_i ? rd_mux : '0;
        end
    end
    assign reg_rdata_o = reg_rdata_q;

    // ========================================================
    // checks
    sequence last_write_s;
        wr_take && at_last && rd_en_q;
    endsequence
    sequence read_back_s;
        rd_back;
    endsequence
    cmd_blocked_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        state_q != SMT_IDLE |-> !cmd_ready_o)
        else $error("control word accepted while busy");
    write_then_read_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        last_write_s |=> state_q == SMT_RD_REQ && addr_q == '0)
        else $error("read pass did not follow writes");
    read_only_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        cmd_take && !cw_wr && cw_rd |=> state_q == SMT_RD_REQ && addr_q == '0)
        else $error("read-only word did not start reading");
    read_restart_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        last_write_s and (sel_q == SMT_SEL_COUNT) |=> expect_val == PAT_COUNT_START)
        else $error("expected data not restarted for read pass");
    word_out_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        read_back_s |=> out_valid_o && out_data_o == $past(mem_rdata_i))
        else $error("read word not offered to output fifo");
    err_leds_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        mismatch |=> pattern_leds_o == 4'hF [*2])
        else $error("mismatch did not light all indicators");
    err_sticky_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        err_q |=> err_q)
        else $error("error indication cleared before reset");
    sel_leds_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        cmd_take && !err_q && !mismatch |=> pattern_leds_o == $past(cw_sel))
        else $error("indicators do not show pattern select");
    blink_toggle_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $changed(blink_q) |-> $past(blink_wrap))
        else $error("indicator toggled off its interval");
endmodule : smt_mem_test

//--- tb/smt_mem_model.sv
// sdram partner model for the memory test bench
`timescale 1ns/100ps
module smt_mem_model #(
    parameter int unsigned AW = 6
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic corrupt_i,
    output logic ready_o,
    output logic rvalid_o,
    output logic [31:0] rdata_o
);
    logic [31:0] mem_q [2**AW];
    logic [31:0] hold_q;
    logic [1:0] wait_q;
    logic pend_q;
    // random accept, random read latency, junk data outside the valid pulse
    always @(posedge mclk_i) begin
        ready_o <= rst_n_i && ($urandom % 3 != 0);
        rvalid_o <= 1'b0;
        rdata_o <= rst_n_i ? ~rdata_o : 32'h0;
        if (!rst_n_i) begin
            pend_q <= 1'b0;
        end else if (rd_i && ready_o) begin
            pend_q <= 1'b1;
            wait_q <= 2'($urandom % 3);
            hold_q <= mem_q[addr_i] ^ {31'h0, corrupt_i};
        end else if (pend_q && wait_q == 2'h0) begin
            pend_q <= 1'b0;
            rvalid_o <= 1'b1;
            rdata_o <= hold_q;
        end else if (pend_q) begin
            wait_q <= wait_q - 2'h1;
        end
        if (rst_n_i && wr_i && ready_o) begin
            mem_q[addr_i] <= wdata_i;
        end
    end
endmodule : smt_mem_model

//--- tb/smt_mem_test_test.sv
// self-checking bench of the sdram pattern memory test
`timescale 1ns/100ps
module smt_mem_test_test;
    import smt_pkg::*;
    localparam int unsigned W = 40;
    localparam int unsigned BLINK = 8;
    localparam int unsigned LOOPS = 5;
    localparam logic [3:0] SELS [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8};
    logic mclk_i = 1'b0;
    logic rd_seen = 1'b0;
    logic rst_n_i, cmd_valid_i, out_ready_i, corrupt, reg_wr_i, reg_rd_i, cmd_ready_o;
    logic out_valid_o, mem_wr_o, mem_rd_o, mem_ready_i, mem_rvalid_i, irq_o, tick, fast, alive;
    logic htick, hfast, halive;
    logic [31:0] cmd_data_i, reg_wdata_i, out_data_o, mem_wdata_o, mem_rdata_i, reg_rdata_o, rd;
    logic [3:0] reg_addr_i, leds, rs;
    logic [5:0] mem_addr_o;
    int fail_count = 0;
    int num_checks = 0;
    // ==========================================================
    // design and memory partner
    smt_mem_test #(.HALVE_FIFO_CLOCK(1'b0), .FIFO_CLOCK_FAST_FLAG(1'b1), .MEM_WORDS(W),
        .ADDR_W(6), .BLINK_TICKS(BLINK)) i_dut (.mclk_i, .rst_n_i, .cmd_valid_i,
        .cmd_data_i, .cmd_ready_o, .out_valid_o, .out_data_o, .out_ready_i, .mem_wr_o,
        .mem_rd_o, .mem_addr_o, .mem_wdata_o, .mem_ready_i, .mem_rvalid_i, .mem_rdata_i,
        .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o,
        .fifo_tick_o(tick), .fifo_clock_fast_flag_o(fast), .clock_alive_indicator_o(alive),
        .pattern_leds_o(leds));
    smt_mem_model #(.AW(6)) i_mem (.mclk_i, .rst_n_i, .wr_i(mem_wr_o), .rd_i(mem_rd_o),
        .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .corrupt_i(corrupt),
        .ready_o(mem_ready_i), .rvalid_o(mem_rvalid_i), .rdata_o(mem_rdata_i));
    // halved fifo clock build, watched for its tick, fast flag and blink only
    smt_mem_test #(.HALVE_FIFO_CLOCK(1'b1), .FIFO_CLOCK_FAST_FLAG(1'b0), .MEM_WORDS(W),
        .ADDR_W(6), .BLINK_TICKS(BLINK)) i_half (.mclk_i, .rst_n_i, .cmd_valid_i(1'b0),
        .cmd_data_i(32'h0), .cmd_ready_o(), .out_valid_o(), .out_data_o(), .out_ready_i(1'b0),
        .mem_wr_o(), .mem_rd_o(), .mem_addr_o(), .mem_wdata_o(), .mem_ready_i(1'b0),
        .mem_rvalid_i(1'b0), .mem_rdata_i(32'h0), .reg_addr_i(4'h0), .reg_wdata_i(32'h0),
        .reg_wr_i(1'b0), .reg_rd_i(1'b0), .reg_rdata_o(), .irq_o(), .fifo_tick_o(htick),
        .fifo_clock_fast_flag_o(hfast), .clock_alive_indicator_o(halive), .pattern_leds_o());
    // clock, output fifo stalls, write-before-read watch
    initial forever #5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) out_ready_i <= rst_n_i && ($urandom % 4 != 0);
    always @(negedge mclk_i) begin
        if (cmd_valid_i === 1'b1 && cmd_ready_o === 1'b1) rd_seen <= 1'b0;
        else if (mem_rd_o === 1'b1) rd_seen <= 1'b1;
        check32(32'(mem_wr_o && rd_seen), 32'h0);
    end
    // ==========================================================
    // expectations and checks
    function automatic logic [31:0] exp_val(input logic [3:0] sel, input int unsigned i);
        case (sel)
            4'h1: return PAT_ONES;
            4'h2: return PAT_ALT01;
            4'h3: return PAT_ALT10;
            4'h4: return PAT_COUNT_START + 32'(i);
            4'h8: return PAT_WALK_START << (i % 32);
            default: return PAT_ZEROS;
        endcase
    endfunction : exp_val
    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check32
    task automatic report_and_stop();
        if (fail_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    task automatic give_up();
        fail_count++;
        $display("[ERR] %0t wait timed out", $time);
        report_and_stop();
    endtask : give_up
    // ==========================================================
    // bus and fifo tasks
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
        @(posedge mclk_i);
    endtask : reg_wr
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        @(negedge mclk_i);
        d = reg_rdata_o;
        @(posedge mclk_i);
    endtask : reg_rd
    task automatic wait_ready();
        for (int k = 0; k <= 3000; k++) begin
            @(negedge mclk_i);
            if (cmd_ready_o === 1'b1) break;
            if (k == 3000) give_up();
        end
    endtask : wait_ready
    task automatic send_cmd(input logic [31:0] w, input logic [3:0] led);
        @(posedge mclk_i);
        cmd_data_i <= w;
        cmd_valid_i <= 1'b1;
        wait_ready();
        @(posedge mclk_i);
        cmd_valid_i <= 1'b0;
        @(negedge mclk_i);
        check32(32'(cmd_ready_o), 32'h0);
        check32(32'(leds), 32'(led));
        @(posedge mclk_i);
    endtask : send_cmd
    task automatic collect(input logic [3:0] sel, input bit chk);
        for (int i = 0; i < W; i++) begin
            for (int k = 0; k <= 200; k++) begin
                @(negedge mclk_i);
                if (out_valid_o === 1'b1 && out_ready_i === 1'b1) break;
                if (k == 200) give_up();
            end
            if (chk) check32(out_data_o, exp_val(sel, i));
        end
        wait_ready();
    endtask : collect
    task automatic blink_check(input bit half);
        int n;
        logic last;
        n = -1;
        last = half ? halive : alive;
        for (int k = 0; k < 8 * BLINK; k++) begin
            @(negedge mclk_i);
            if (n >= 0) n++;
            if ((half ? halive : alive) !== last && n > 0) break;
            if ((half ? halive : alive) !== last) n = 0;
            last = half ? halive : alive;
        end
        check32(32'(n), half ? 2 * BLINK : BLINK);
    endtask : blink_check
    // ==========================================================
    // main sequence
    initial begin
        {rst_n_i, cmd_valid_i, reg_wr_i, reg_rd_i, corrupt} = 5'h0;
        {cmd_data_i, reg_wdata_i, reg_addr_i} = 68'h0;
        void'($urandom(32'hE1F4));
        repeat (16) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(negedge mclk_i);
        check32(32'({htick, hfast, tick, fast, irq_o, leds}), 32'h60);
        @(negedge mclk_i);
        check32(32'({htick, tick}), 32'h3);
        blink_check(1'b0);
        blink_check(1'b1);
        reg_rd(4'h1, rd);
        check32(rd, 32'h0);
        reg_rd(REG_IRQ_MASK, rd);
        check32(rd, 32'h0);
        reg_wr(REG_IRQ_MASK, 32'h1);
        repeat (LOOPS) foreach (SELS[s]) begin
            send_cmd(32'h30 | 32'(SELS[s]), SELS[s]);
            collect(SELS[s], 1'b1);
            reg_rd(REG_READ_WORDS, rd);
            check32(rd, W);
            check32(32'(irq_o), 32'h1);
            reg_wr(REG_IRQ_STAT, 32'h7);
            check32(32'(irq_o), 32'h0);
        end
        // empty word with a random select: no pass runs, done at once
        rs = SELS[$urandom % 6];
        @(posedge mclk_i);
        cmd_data_i <= 32'(rs);
        cmd_valid_i <= 1'b1;
        wait_ready();
        @(posedge mclk_i);
        cmd_valid_i <= 1'b0;
        reg_rd(REG_IRQ_STAT, rd);
        check32(rd, 32'h1);
        check32(32'(cmd_ready_o), 32'h1);
        check32(32'(leds), 32'(rs));
        // read errors light all indicators, interrupt masked
        reg_wr(REG_IRQ_MASK, 32'h0);
        corrupt <= 1'b1;
        send_cmd(32'h32, 4'h2);
        collect(4'h2, 1'b0);
        corrupt <= 1'b0;
        check32(32'({leds, irq_o}), 32'h1E);
        reg_rd(REG_IRQ_STAT, rd);
        check32(rd & 32'h2, 32'h2);
        send_cmd(32'h74, 4'hF);
        collect(4'h4, 1'b1);
        reg_rd(REG_IRQ_STAT, rd);
        check32(rd & 32'h4, 32'h4);
        // write-only pass, then read-only pass of the same pattern
        send_cmd(32'h18, 4'hF);
        wait_ready();
        send_cmd(32'h28, 4'hF);
        collect(4'h8, 1'b1);
        @(posedge mclk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(negedge mclk_i);
        check32(32'(leds), 32'h0);
        report_and_stop();
    end
endmodule : smt_mem_test_test
